// >>> stepper_position_state_control.sv
// position-controller state machine and parameter ram of the stepper controller
// Operation
// - after reset sit in shutdown until a status-one read has been taken
// - init run uses its own parameter set, unspecified ones copied from ram
// - second init motion forces flat ramp; reloads apply to ram only
// - status-one read reports ram start and top velocity, not init values
// - shutdown is left only when overheat and hard-stop flags are clear
// - fault flags clear on status-one read only when condition is gone
// - config writes during init run do not touch that run
// - safe position valid unless register holds most negative code
// - stop flag set on leaving halt states, cleared first edge in stopped
// - stopped with position mismatch resumes moving, lowest priority
// - lost step blocks set-target and goto-safe commands in every state
// - other commands still run while lost step is set
// - lost step flag clears only through a status-one read
// - ram parameters load from otp defaults with ramp select forced to accel; all but safe position and microstep stay writable
// - actual position is 16-bit signed, readable, clearable
// - target position 16-bit signed, resets to zero, written by set-target
// - ramp select zero accelerates with accel rate, one runs at start velocity
// - run current during motion, hold current at standstill
// - velocity and accel fields 4 bits, direction 1 bit, microstep 2 bits
`timescale 1ns/1ps
module stepper_position_state_control
	import stepper_ctrl_pkg::*;
#(
	parameter int UNIT_CYC = STEP_UNIT_CYC
) (
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// command port from the serial front end
	input  wire logic          cmd_valid,
	input  wire cmd_t          cmd,
	// one-time-programmable defaults
	input  wire motor_cfg_t    otp_cfg,
	// analog fault pins
	input  wire logic          overtemp_pin,
	input  wire logic          undervolt_pin,
	input  wire logic          elec_defect_pin,
	input  wire logic          pump_fail_pin,
	// read answers
	output logic               resp_one_valid,
	output status_one_t        resp_one,
	output logic               resp_two_valid,
	output status_two_t        resp_two,
	// motion and coil outputs
	output motion_state_t      state,
	output logic [15:0]        actual_position,
	output logic [15:0]        target_position,
	output logic               step_pulse,
	output logic               step_dir,
	output logic [3:0]         coil_current,
	output logic               bridge_enable,
	output logic               safe_position_valid
);

	function automatic logic safe_enabled(input logic [10:0] pos);
		safe_enabled = (pos != SAFE_POS_DISABLED);
	endfunction

	// fault pins come from the analog side, so two flops first
	logic [3:0] fault_meta;
	logic [3:0] fault_sync;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fault_meta <= 4'h0;
			fault_sync <= 4'h0;
		end else begin
			fault_meta <= {overtemp_pin, undervolt_pin, elec_defect_pin, pump_fail_pin};
			fault_sync <= fault_meta;
		end
	end
	logic overtemp;
	logic elec_fault;
	assign overtemp = fault_sync[3];
	assign elec_fault = |fault_sync[2:0];

	// command decode
	logic do_read1, do_read2, do_write, do_set, do_safe, do_init, do_clear, do_reload;
	logic do_hard, do_soft;
	always_comb begin
		do_read1 = cmd_valid && cmd.code == CMD_READ_ONE;
		do_read2 = cmd_valid && cmd.code == CMD_READ_TWO;
		do_write = cmd_valid && cmd.code == CMD_WRITE_CFG;
		do_set = cmd_valid && cmd.code == CMD_SET_TARGET;
		do_safe = cmd_valid && cmd.code == CMD_GOTO_SAFE;
		do_init = cmd_valid && cmd.code == CMD_INIT_RUN;
		do_clear = cmd_valid && cmd.code == CMD_CLEAR_POS;
		do_reload = cmd_valid && cmd.code == CMD_RELOAD;
		do_hard = cmd_valid && cmd.code == CMD_HARD_HALT;
		do_soft = cmd_valid && cmd.code == CMD_SOFT_HALT;
	end

	// flags
	logic supply_reset_flag, overheat_flag, hard_stop_flag, lost_step_flag, stop_flag;
	logic read_seen;
	logic set_ok, safe_ok, target_state;
	assign target_state = state inside {ST_STOPPED, ST_MOVING, ST_INIT};
	assign set_ok = do_set && !lost_step_flag && target_state;
	assign safe_ok = do_safe && !lost_step_flag && target_state && safe_position_valid;

	// parameter ram and the separate init-run set
	motor_cfg_t ram, next_ram, init_cfg;
	logic       otp_loaded;
	logic       init_phase;
	logic [15:0] init_goal;
	logic [15:0] init_second;

	always_comb begin
		next_ram = ram;
		if (!otp_loaded || do_reload) begin
			next_ram = otp_cfg;
			next_ram.ramp_shape_sel = ramp_shape_ACCEL;
		end else if (do_write) begin
			// safe position and stepping mode come only from otp
			next_ram = cmd.cfg;
			next_ram.safe_position = ram.safe_position;
			next_ram.microstep_sel = ram.microstep_sel;
		end
	end

	// otp copy waits one edge after reset so no port feeds an async load
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ram <= '0;
			otp_loaded <= 1'b0;
			safe_position_valid <= 1'b0;
		end else begin
			ram <= next_ram;
			otp_loaded <= 1'b1;
			safe_position_valid <= safe_enabled(next_ram.safe_position);
		end
	end

	// active motion parameters
	motor_cfg_t act;
	logic [15:0] goal;
	always_comb begin
		act = (state == ST_INIT) ? init_cfg : ram;
		if (state == ST_INIT && init_phase)
			act.ramp_shape_sel = ramp_shape_FLAT;
		goal = (state == ST_INIT) ? init_goal : target_position;
	end

	// step timing: unit tick, step interval shrinks with velocity
	logic [$clog2(UNIT_CYC+1)-1:0] unit_cnt;
	logic       unit_tick;
	logic [4:0] step_cnt;
	logic [3:0] velocity;
	logic [3:0] accel_cnt;
	logic       moving, at_goal, step_now, soft_done;
	assign unit_tick = (unit_cnt == '0);
	assign moving = state inside {ST_MOVING, ST_INIT, ST_RAMPED};
	assign at_goal = (actual_position == goal);
	// no step on the edge that ends a ramped halt, else target lags actual by one
	assign step_now = moving && unit_tick && step_cnt == 5'h00 && !at_goal
		&& !(state == ST_RAMPED && soft_done);
	assign soft_done = (velocity <= act.start_velocity) || at_goal;

	// state transitions
	motion_state_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			ST_SHUTDOWN: begin
				if (read_seen && !overheat_flag && !hard_stop_flag)
					next_state = ST_STOPPED;
			end
			ST_STOPPED: begin
				if (elec_fault || overtemp)
					next_state = ST_SHUTDOWN;
				else if (do_init)
					next_state = ST_INIT;
				else if (set_ok || safe_ok)
					next_state = ST_MOVING;
				else if (!stop_flag && actual_position != target_position)
					next_state = ST_MOVING;
			end
			ST_MOVING, ST_INIT: begin
				if (elec_fault || do_hard)
					next_state = ST_ABRUPT;
				else if (overtemp || (do_soft && state == ST_MOVING))
					next_state = ST_RAMPED;
				else if (at_goal && (state == ST_MOVING || init_phase))
					next_state = ST_STOPPED;
			end
			ST_RAMPED: begin
				if (elec_fault || do_hard)
					next_state = ST_ABRUPT;
				else if (soft_done)
					next_state = ST_STOPPED;
			end
			ST_ABRUPT: next_state = ST_STOPPED;
			default: next_state = ST_SHUTDOWN;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			state <= ST_SHUTDOWN;
		else
			state <= next_state;
	end

	// init run snapshot and phase
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			init_cfg <= '0;
			init_phase <= 1'b0;
			init_goal <= 16'h0000;
			init_second <= 16'h0000;
		end else if (state != ST_INIT && next_state == ST_INIT) begin
			init_cfg <= ram;
			if (cmd.init_start_given)
				init_cfg.start_velocity <= cmd.cfg.start_velocity;
			if (cmd.init_top_given)
				init_cfg.top_velocity <= cmd.cfg.top_velocity;
			init_phase <= 1'b0;
			init_goal <= cmd.target;
			// second leg latched now; the command word moves on
			init_second <= cmd.second_target;
		end else if (state == ST_INIT && at_goal && !init_phase) begin
			init_phase <= 1'b1;
			init_goal <= init_second;
		end
	end

	// positions
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			target_position <= TARGET_RESET;
			actual_position <= ACTUAL_RESET;
		end else begin
			if (step_now)
				actual_position <= $signed(goal) > $signed(actual_position) ?
					actual_position + 16'h0001 : actual_position - 16'h0001;
			if (do_clear && state inside {ST_STOPPED, ST_SHUTDOWN}) begin
				target_position <= 16'h0000;
				actual_position <= 16'h0000;
			end else if ((state == ST_ABRUPT || state == ST_RAMPED) && next_state == ST_STOPPED)
				target_position <= actual_position;
			else if (set_ok)
				target_position <= cmd.target;
			else if (safe_ok)
				target_position <= {ram.safe_position, SAFE_POS_FILL};
		end
	end

	// velocity profile; no deceleration before the goal, the step simply stops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			unit_cnt <= '0;
			step_cnt <= 5'h00;
			velocity <= 4'h0;
			accel_cnt <= 4'h0;
		end else begin
			unit_cnt <= unit_tick ? ($bits(unit_cnt))'(UNIT_CYC - 1) : unit_cnt - 1'b1;
			if (!moving) begin
				velocity <= act.start_velocity;
				step_cnt <= 5'h00;
				accel_cnt <= 4'h0;
			end else if (unit_tick) begin
				if (step_cnt != 5'h00)
					step_cnt <= step_cnt - 5'h01;
				else if (!at_goal) begin
					step_cnt <= 5'h10 - {1'b0, velocity};
					accel_cnt <= accel_cnt + 4'h1;
					if (accel_cnt == ~act.accel_rate) begin
						accel_cnt <= 4'h0;
						if (state == ST_RAMPED) begin
							if (velocity != 4'h0)
								velocity <= velocity - 4'h1;
						end else if (act.ramp_shape_sel == ramp_shape_ACCEL
							&& velocity < act.top_velocity)
							velocity <= velocity + 4'h1;
					end
					if (act.ramp_shape_sel == ramp_shape_FLAT && state != ST_RAMPED)
						velocity <= act.start_velocity;
				end
			end
		end
	end

	// flags; a hardware set always wins over the clear of a read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			supply_reset_flag <= 1'b1;
			overheat_flag <= 1'b0;
			hard_stop_flag <= 1'b0;
			lost_step_flag <= 1'b0;
			read_seen <= 1'b0;
		end else begin
			if (do_read1)
				supply_reset_flag <= 1'b0;
			if (do_read1)
				read_seen <= 1'b1;
			if (overtemp)
				overheat_flag <= 1'b1;
			else if (do_read1)
				overheat_flag <= 1'b0;
			if (elec_fault)
				hard_stop_flag <= 1'b1;
			else if (do_read1)
				hard_stop_flag <= 1'b0;
			if (next_state == ST_ABRUPT && state != ST_ABRUPT)
				lost_step_flag <= 1'b1;
			else if (do_read1)
				lost_step_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			stop_flag <= 1'b0;
		else if (state inside {ST_ABRUPT, ST_RAMPED} && next_state != state)
			stop_flag <= 1'b1;
		else if (state == ST_STOPPED)
			stop_flag <= 1'b0;
	end

	// read answers carry flag values as they stood before the clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			resp_one_valid <= 1'b0;
			resp_two_valid <= 1'b0;
			resp_one <= '0;
			resp_two <= '0;
		end else begin
			resp_one_valid <= do_read1;
			resp_two_valid <= do_read2;
			if (do_read1)
				resp_one <= '{supply_reset_flag, overheat_flag, hard_stop_flag,
					lost_step_flag, stop_flag, safe_position_valid, ram};
			if (do_read2)
				resp_two <= '{actual_position, target_position,
					ram.safe_position, ram.microstep_sel};
		end
	end

	// coil side
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			step_pulse <= 1'b0;
			step_dir <= 1'b0;
			coil_current <= 4'h0;
			bridge_enable <= 1'b0;
		end else begin
			step_pulse <= step_now;
			step_dir <= ($signed(goal) > $signed(actual_position)) ^ act.motor_direction;
			coil_current <= moving ? act.run_current : act.hold_current;
			bridge_enable <= (state != ST_SHUTDOWN);
		end
	end

	// checks
	sequence s_halt_exit;
		state inside {ST_ABRUPT, ST_RAMPED} ##1 state == ST_STOPPED;
	endsequence
	sequence s_stop_cleared;
		stop_flag ##1 !stop_flag;
	endsequence

	AST_HALT_STOP_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_halt_exit |-> s_stop_cleared)
		else $error("stop flag not set then cleared after halt");
	AST_NO_EARLY_EXIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == ST_SHUTDOWN && !read_seen |=> state == ST_SHUTDOWN)
		else $error("shutdown left before status read");
	AST_EXIT_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == ST_SHUTDOWN && $past(state) == ST_SHUTDOWN && (overheat_flag || hard_stop_flag)
		|=> state == ST_SHUTDOWN)
		else $error("shutdown left with fault flag set");
	AST_LOST_STEP_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		lost_step_flag && !do_read1 |=> lost_step_flag)
		else $error("lost step cleared without status read");
	AST_TARGET_LOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
		lost_step_flag && (do_set || do_safe) && !do_clear
		&& !(state inside {ST_ABRUPT, ST_RAMPED}) |=> $stable(target_position))
		else $error("target changed while lost step set");
	AST_SAFE_VALID: assert property (@(posedge clk_sys) disable iff (!rst_n)
		otp_loaded |-> safe_position_valid == (ram.safe_position != 11'h400))
		else $error("safe position valid wrong");
	AST_RESUME_LOW_PRIO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == ST_STOPPED && overtemp |=> state == ST_SHUTDOWN)
		else $error("overtemp did not take priority in stopped");
	AST_CURRENT: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == ST_STOPPED && $stable(ram) |=> coil_current == $past(ram.hold_current))
		else $error("hold current not used at standstill");
	AST_INIT_FLAT: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == ST_INIT && init_phase |-> act.ramp_shape_sel == 1'b1)
		else $error("second init motion not flat");
	AST_READ_VEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
		do_read1 ##1 resp_one_valid |-> resp_one.cfg.top_velocity == $past(ram.top_velocity))
		else $error("status read reported wrong velocity");
	AST_CLEAR_POS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		do_clear && state == ST_STOPPED |=> actual_position == 16'h0000)
		else $error("clear position did not clear");

endmodule

// >>> stepper_ctrl_pkg.sv
// shared types and constants of the stepper position controller
package stepper_ctrl_pkg;

	localparam int CLK_PERIOD_NS = 5;
	localparam int STEP_UNIT_NS = 1000;
	localparam int STEP_UNIT_CYC = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [10:0] SAFE_POS_DISABLED = 11'h400;
	localparam logic [15:0] TARGET_RESET = 16'h0000;
	localparam logic [15:0] ACTUAL_RESET = 16'h0000;
	localparam int SAFE_POS_LSBS = 5;
	localparam logic [4:0] SAFE_POS_FILL = 5'h00;
	localparam logic ramp_shape_ACCEL = 1'b0;
	localparam logic ramp_shape_FLAT = 1'b1;

	typedef enum logic [3:0] {
		CMD_NONE       = 4'h0,
		CMD_READ_ONE   = 4'h1,
		CMD_READ_TWO   = 4'h2,
		CMD_WRITE_CFG  = 4'h3,
		CMD_SET_TARGET = 4'h4,
		CMD_GOTO_SAFE  = 4'h5,
		CMD_INIT_RUN   = 4'h6,
		CMD_CLEAR_POS  = 4'h7,
		CMD_RELOAD     = 4'h8,
		CMD_HARD_HALT  = 4'h9,
		CMD_SOFT_HALT  = 4'ha
	} cmd_code_t;

	typedef enum logic [5:0] {
		ST_SHUTDOWN = 6'h01,
		ST_STOPPED  = 6'h02,
		ST_MOVING   = 6'h04,
		ST_INIT     = 6'h08,
		ST_ABRUPT   = 6'h10,
		ST_RAMPED   = 6'h20
	} motion_state_t;

	typedef struct packed {
		logic        ramp_shape_sel;
		logic [3:0]  run_current;
		logic [3:0]  hold_current;
		logic [3:0]  start_velocity;
		logic [3:0]  top_velocity;
		logic        motor_direction;
		logic [3:0]  accel_rate;
		logic [10:0] safe_position;
		logic [1:0]  microstep_sel;
	} motor_cfg_t;

	typedef struct packed {
		cmd_code_t   code;
		motor_cfg_t  cfg;
		logic [15:0] target;
		logic [15:0] second_target;
		logic        init_start_given;
		logic        init_top_given;
	} cmd_t;

	typedef struct packed {
		logic       supply_reset_flag;
		logic       overheat_shutdown_flag;
		logic       hard_stop_flag;
		logic       lost_step_flag;
		logic       stop_flag;
		logic       safe_position_valid;
		motor_cfg_t cfg;
	} status_one_t;

	typedef struct packed {
		logic [15:0] actual_position;
		logic [15:0] target_position;
		logic [10:0] safe_position;
		logic [1:0]  microstep_sel;
	} status_two_t;

endpackage

// >>> host_master.sv
// host master model issuing one-word commands to the position controller
`timescale 1ns/1ps
module host_master
	import stepper_ctrl_pkg::*;
(
	// clock and controller state
	input  wire logic clk_sys,
	input  wire logic moving,
	// command port
	output logic      cmd_valid,
	output cmd_t      cmd
);
	motor_cfg_t shadow;

	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
		shadow = '0;
	end

	task automatic send(input cmd_t c);
		cmd_t w;
		w = c;
		// keep accel and start velocity while a move runs
		if (moving && c.code == CMD_WRITE_CFG) begin
			w.cfg.accel_rate = shadow.accel_rate;
			w.cfg.start_velocity = shadow.start_velocity;
		end
		if (w.code == CMD_WRITE_CFG)
			shadow = w.cfg;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd <= w;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		// idle word inverted so a stale command never looks fresh
		cmd <= cmd_t'(~w);
	endtask
endmodule

// >>> tb.sv
// self-checking bench of the stepper position state control
`timescale 1ns/1ps
module tb;
	import stepper_ctrl_pkg::*;
	localparam int UC = 2;
	logic          clk_sys = 1'b0;
	logic          rst_n = 1'b0;
	logic          cmd_valid;
	cmd_t          cmd;
	motor_cfg_t    otp_cfg;
	logic [3:0]    pins = 4'h0;
	logic          resp_one_valid;
	logic          resp_two_valid;
	status_one_t   resp_one;
	status_two_t   resp_two;
	motion_state_t state;
	logic [15:0]   actual_position;
	logic [15:0]   target_position;
	logic          step_pulse;
	logic          step_dir;
	logic [3:0]    coil_current;
	logic          bridge_enable;
	logic          safe_position_valid;
	int            num_errors = 0;
	int            compares = 0;
	logic [31:0]   seed = 32'h2c1b;
	motor_cfg_t    ram;
	status_one_t   r1;
	cmd_t          c = '0;
	logic [15:0]   t;
	int            steps = 0;

	always #2.5 clk_sys = ~clk_sys;

	// pulses counted at the edge after they launch
	always @(posedge clk_sys)
		if (step_pulse === 1'b1)
			steps++;

	host_master host (.clk_sys(clk_sys), .moving(state === ST_MOVING), .cmd_valid(cmd_valid),
		.cmd(cmd));

	stepper_position_state_control #(.UNIT_CYC(UC)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
		.cmd_valid(cmd_valid), .cmd(cmd), .otp_cfg(otp_cfg), .overtemp_pin(pins[0]),
		.undervolt_pin(pins[1]), .elec_defect_pin(pins[2]), .pump_fail_pin(pins[3]),
		.resp_one_valid(resp_one_valid), .resp_one(resp_one), .resp_two_valid(resp_two_valid),
		.resp_two(resp_two), .state(state), .actual_position(actual_position),
		.target_position(target_position), .step_pulse(step_pulse), .step_dir(step_dir),
		.coil_current(coil_current), .bridge_enable(bridge_enable),
		.safe_position_valid(safe_position_valid));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic tally_and_finish();
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic wait_state(input motion_state_t s, input int n);
		for (int i = 0; i < n && state !== s; i++)
			tick(1);
		if (state !== s) begin
			chk(state, s, "state wait");
			tally_and_finish();
		end
	endtask

	task automatic op(input cmd_code_t k, input logic [15:0] tg);
		c.code = k;
		c.target = tg;
		host.send(c);
		#1;
	endtask

	task automatic rd(input bit two);
		op(two ? CMD_READ_TWO : CMD_READ_ONE, 16'h0);
		for (int i = 0; i < 3 && (two ? resp_two_valid : resp_one_valid) !== 1'b1; i++)
			tick(1);
		chk(two ? resp_two_valid : resp_one_valid, 1'b1, "resp valid");
		r1 = resp_one;
	endtask

	task automatic clear_pos();
		op(CMD_CLEAR_POS, 16'h0);
		tick(1);
		chk({actual_position, target_position}, 32'h0, "clear pos");
	endtask

	task automatic move_to(input cmd_code_t k, input logic [15:0] tg);
		int s0;
		int d;
		logic dir_exp;
		s0 = steps;
		d = $signed(tg);
		if (d < 0)
			d = -d;
		dir_exp = ($signed(tg) > 0) ^ ram.motor_direction;
		op(k, tg);
		wait_state(ST_MOVING, 3);
		chk(target_position, tg, "target");
		tick(2);
		chk({coil_current, step_dir}, {ram.run_current, dir_exp}, "run current dir");
		wait_state(ST_STOPPED, 4000);
		chk({actual_position, bridge_enable}, {tg, 1'b1}, "actual");
		chk(steps - s0, d, "step count");
		tick(2);
		chk(coil_current, ram.hold_current, "hold current");
		rd(1);
		chk({resp_two.actual_position, resp_two.target_position}, {tg, tg}, "status two");
	endtask

	initial begin
		otp_cfg = motor_cfg_t'(35'({rnd(), rnd()}));
		otp_cfg.safe_position = SAFE_POS_DISABLED;
		// fast defaults keep every move short
		otp_cfg.start_velocity = 4'hf;
		otp_cfg.top_velocity = 4'hf;
		ram = otp_cfg;
		ram.ramp_shape_sel = 1'b0;
		tick(6);
		rst_n <= 1'b1;
		tick(3);
		chk({state, target_position}, {ST_SHUTDOWN, TARGET_RESET}, "reset");
		chk(safe_position_valid, 1'b0, "safe valid");
		chk(bridge_enable, 1'b0, "bridge off");
		tick(20);
		chk(state, ST_SHUTDOWN, "shutdown held");
		rd(0);
		chk(r1.supply_reset_flag, 1'b1, "supply flag");
		chk(r1.cfg, ram, "otp defaults");
		wait_state(ST_STOPPED, 10);
		for (int i = 0; i < 6; i++) begin
			c.cfg = motor_cfg_t'(35'({rnd(), rnd()}));
			if (i == 5) begin
				c.cfg.start_velocity = 4'hf;
				c.cfg.top_velocity = 4'hf;
				c.cfg.motor_direction = 1'b0;
			end
			op(CMD_WRITE_CFG, 16'h0);
			ram = motor_cfg_t'({c.cfg[34:13], ram[12:0]});
			rd(0);
			chk(r1.cfg, ram, "cfg write");
		end
		for (int i = 0; i < 3; i++) begin
			clear_pos();
			t = 16'(rnd() % 56 + 8);
			if (rnd() & 1)
				t = -t;
			move_to(CMD_SET_TARGET, t);
		end
		// disabled safe position refuses the move
		op(CMD_GOTO_SAFE, 16'h0);
		tick(3);
		chk({state, target_position}, {ST_STOPPED, t}, "safe refused");
		@(posedge clk_sys);
		otp_cfg.safe_position <= 11'h002;
		tick(1);
		op(CMD_RELOAD, 16'h0);
		ram = otp_cfg;
		ram.ramp_shape_sel = 1'b0;
		rd(0);
		chk(r1.cfg, ram, "reload");
		chk(safe_position_valid, 1'b1, "safe valid");
		clear_pos();
		move_to(CMD_GOTO_SAFE, {11'h002, SAFE_POS_FILL});
		clear_pos();
		op(CMD_SET_TARGET, 16'h0100);
		tick(40);
		op(CMD_HARD_HALT, 16'h0);
		wait_state(ST_STOPPED, 10);
		op(CMD_SET_TARGET, 16'h0200);
		op(CMD_GOTO_SAFE, 16'h0);
		tick(3);
		chk(state, ST_STOPPED, "lost step state");
		chk(target_position, actual_position, "lost step target");
		clear_pos();
		rd(0);
		chk(r1.lost_step_flag, 1'b1, "lost step kept");
		rd(0);
		chk(r1.lost_step_flag, 1'b0, "lost step cleared");
		op(CMD_SET_TARGET, 16'h0100);
		tick(40);
		op(CMD_SOFT_HALT, 16'h0);
		wait_state(ST_STOPPED, 2000);
		tick(4);
		chk({state, target_position}, {ST_STOPPED, actual_position}, "soft halt");
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			pins[i] <= 1'b1;
			wait_state(ST_SHUTDOWN, 20);
			rd(0);
			chk(i == 0 ? r1.overheat_shutdown_flag : r1.hard_stop_flag, 1'b1, "fault flag");
			tick(6);
			chk({state, bridge_enable}, {ST_SHUTDOWN, 1'b0}, "fault held");
			@(posedge clk_sys);
			pins[i] <= 1'b0;
			tick(6);
			rd(0);
			rd(0);
			chk({r1.overheat_shutdown_flag, r1.hard_stop_flag}, 2'b00, "flags clear");
			wait_state(ST_STOPPED, 20);
		end
		clear_pos();
		c.cfg.start_velocity = 4'he;
		c.cfg.top_velocity = 4'he;
		c.second_target = 16'h0000;
		c.init_start_given = 1'b1;
		c.init_top_given = 1'b1;
		op(CMD_INIT_RUN, 16'h0010);
		wait_state(ST_INIT, 3);
		rd(0);
		chk({r1.cfg.start_velocity, r1.cfg.top_velocity}, {ram.start_velocity, ram.top_velocity},
			"init velocities");
		op(CMD_WRITE_CFG, 16'h0);
		ram = motor_cfg_t'({c.cfg[34:13], ram[12:0]});
		rd(0);
		chk(r1.cfg, ram, "init cfg write");
		op(CMD_RELOAD, 16'h0);
		ram = otp_cfg;
		ram.ramp_shape_sel = 1'b0;
		rd(0);
		chk({state, r1.cfg}, {ST_INIT, ram}, "init reload");
		wait_state(ST_STOPPED, 3000);
		chk(actual_position, 16'h0000, "init end");
		tally_and_finish();
	end
endmodule
